// ==== lgate_top.sv ====
// Operation
// R1 - Lasing is allowed only while the safety interlock input is asserted.
// R2 - With a key, a reasserted interlock waits for a key or restart toggle, then a 5 s delay.
// R3 - Without a key, a reasserted interlock re-enables at once if the gate request is present.
// R4 - Drive follows the duty cycle of the power command pulse train.
// R5 - The controller keeps the power command near 5 kHz and never above 160 kHz. The controller model's period is 1600 cycles, 156.25 kHz at 250 MHz.
// R6 - Lasing is allowed only while the beam gate request is asserted.
// R7 - With a key, lasing waits 5 s after the gate request becomes asserted.
// R8 - With a key, both the gate request and the shutter switch must be open.
// R9 - The controller waits about 200 ms after power-up before pulsing restart.
// R10 - Restart held keeps the laser off; its release sets ready, with a 5 s delay if keyed. The code shows ready_out from the start of arming, before the delay.
// R11 - RF drive stays off until ready and beam gate open are active together.
// R12 - Inputs are synchronised and the arming counter restarts when arming is lost.
//
// Purpose: Decide when RF drive and lasing are permitted
// Assumes: All user inputs asynchronous, active high
// Notes: ARM_CYCLES is a parameter so simulation can shorten it
`timescale 1ns/1ps
`include "lgate_cfg.svh"
module lgate_top #(
	parameter int unsigned ARM_CYCLES = `LGATE_ARM_CYCLES,
	parameter bit HAS_KEY = 1'b1
) (
	// Clock and reset
	clk,
	rst,
	// User inputs
	interlock_in,
	gate_request_in,
	restart_in,
	pwm_in,
	// Front panel
	key_on_in,
	shutter_open_in,
	// Status and drive
	ready_out,
	beam_gate_indicator,
	rf_enable,
	rf_drive
);
	input wire logic clk;
	input wire logic rst;
	input wire logic interlock_in;
	input wire logic gate_request_in;
	input wire logic restart_in;
	input wire logic pwm_in;
	input wire logic key_on_in;
	input wire logic shutter_open_in;
	output logic ready_out;
	output logic beam_gate_indicator;
	output logic rf_enable;
	output logic rf_drive;

	// Zero cycles would leave the arming state with no exit
	if (ARM_CYCLES < 1) begin : g_bad_arm
		$error("ARM_CYCLES must be at least one");
	end

	////////////////////////////////////////////////////////////////
	localparam int NIN = 6;
	logic [NIN-1:0] raw, syn;
	assign raw = {pwm_in, shutter_open_in, key_on_in, restart_in, gate_request_in, interlock_in};

	// R12 input synchronisers
	genvar gi;
	generate
		for (gi = 0; gi < NIN; gi++) begin : g_sync
			lgate_sync u_sync (
				.clk(clk),
				.rst(rst),
				.in_async(raw[gi]),
				.out_sync(syn[gi])
			);
		end
	endgenerate

	logic ilk, req, rstr, key, shut, pwm;
	assign {pwm, shut, key, rstr, req, ilk} = syn;

	////////////////////////////////////////////////////////////////
	lgate_pkg::lgate_state_t st_q, st_d;
	logic [31:0] cnt_q, cnt_d;
	logic key_q, key_d, rstr_q, rstr_d;
	logic rdy_q, rdy_d, bgi_q, bgi_d, en_q, en_d, drv_q, drv_d;
	logic gate_ok, toggled;

	// Keyed variant also needs the manual shutter open
	function automatic logic gate_open(input logic request, input logic shutter);
		return HAS_KEY ? (request && shutter) : request;
	endfunction

	// Ready covers the arming delay as well as full readiness
	function automatic logic shows_ready(input lgate_pkg::lgate_state_t s);
		return (s == lgate_pkg::LGATE_ST_READY) || (s == lgate_pkg::LGATE_ST_ARMING);
	endfunction

	// Only the final state may light the RF stage
	function automatic logic may_lase(input lgate_pkg::lgate_state_t s);
		return s == lgate_pkg::LGATE_ST_READY;
	endfunction

	////////////////////////////////////////////////////////////////
	// R2 edge history
	// Reset to low, so a key already on after reset looks like a turn;
	// the latched state, entered after reset while the synced interlock still reads low, is left on that turn
	always_comb begin
		key_d = key;
		rstr_d = rstr;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			key_q <= 1'b0;
			rstr_q <= 1'b0;
		end else begin
			key_q <= key_d;
			rstr_q <= rstr_d;
		end
	end

	////////////////////////////////////////////////////////////////
	// Arming state and delay counter
	always_comb begin
		// R8 gate request and shutter switch
		gate_ok = gate_open(req, shut);
		// R2 key or restart toggle releases latch
		toggled = (key && !key_q) || (!rstr && rstr_q);
		st_d = st_q;
		cnt_d = cnt_q;
		case (st_q)
			lgate_pkg::LGATE_ST_OFF: begin
				cnt_d = 32'h0;
				// R3 unkeyed interlock not latched
				if (ilk && !rstr && (!HAS_KEY || key))
					st_d = HAS_KEY ? lgate_pkg::LGATE_ST_ARMING : lgate_pkg::LGATE_ST_READY;
			end
			lgate_pkg::LGATE_ST_WAIT_RESTART: begin
				cnt_d = 32'h0;
				// R2 latched until toggle
				if (!ilk)
					st_d = lgate_pkg::LGATE_ST_WAIT_RESTART;
				else if (toggled && key && !rstr)
					st_d = lgate_pkg::LGATE_ST_ARMING;
			end
			lgate_pkg::LGATE_ST_ARMING: begin
				// R12 counter restarts when arming lost
				if (!gate_ok)
					cnt_d = 32'h0;
				else
					cnt_d = cnt_q + 32'h1;
				// R7 five second wait
				if (gate_ok && cnt_q >= ARM_CYCLES - 1)
					st_d = lgate_pkg::LGATE_ST_READY;
			end
			lgate_pkg::LGATE_ST_READY: begin
				cnt_d = 32'h0;
				// R7 new gate request rearms
				if (HAS_KEY && !gate_ok)
					st_d = lgate_pkg::LGATE_ST_ARMING;
			end
			default: st_d = lgate_pkg::LGATE_ST_OFF;
		endcase
		// R10 restart held disables
		if (rstr)
			st_d = lgate_pkg::LGATE_ST_OFF;
		// R1 interlock loss
		if (!ilk)
			st_d = HAS_KEY ? lgate_pkg::LGATE_ST_WAIT_RESTART : lgate_pkg::LGATE_ST_OFF;
		// R2 key off drops arming
		if (HAS_KEY && !key && ilk && !rstr)
			st_d = lgate_pkg::LGATE_ST_OFF;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_q <= lgate_pkg::LGATE_ST_OFF;
			cnt_q <= 32'h0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
		end
	end

	////////////////////////////////////////////////////////////////
	// Status and drive, decoded from the next state (beam gate indicator from gate_ok) so that
	// the outputs stay one flop away from the pins
	always_comb begin
		// R10 ready shown after release
		rdy_d = shows_ready(st_d);
		// R6 beam gate indicator
		bgi_d = gate_ok;
		// R11 both ready and gate open
		en_d = ilk && may_lase(st_d) && gate_ok;
		// R4 drive follows command duty
		drv_d = en_d && pwm;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rdy_q <= 1'b0;
			bgi_q <= 1'b0;
			en_q <= 1'b0;
			drv_q <= 1'b0;
		end else begin
			rdy_q <= rdy_d;
			bgi_q <= bgi_d;
			en_q <= en_d;
			drv_q <= drv_d;
		end
	end

	////////////////////////////////////////////////////////////////
	// Registered outputs

	assign ready_out = rdy_q;
	assign beam_gate_indicator = bgi_q;
	assign rf_enable = en_q;
	assign rf_drive = drv_q;
endmodule

// ==== lgate_cfg.svh ====
// Purpose: Constants for the laser enable gating block
// Assumes: 250 MHz clock
// Notes: Times in their own units, counts derived
`ifndef LGATE_CFG_SVH
`define LGATE_CFG_SVH
`define LGATE_CLK_MHZ 250
`define LGATE_ARM_DELAY_MS 5000
`define LGATE_ARM_CYCLES (`LGATE_ARM_DELAY_MS * 1000 * `LGATE_CLK_MHZ)
`define LGATE_PWM_MAX_KHZ 160
`define LGATE_SYNC_STAGES 3
`endif

// ==== lgate_pkg.sv ====
// Purpose: Types for the laser enable gating block
// Assumes: Nothing
// Notes: Arming state encoding
package lgate_pkg;
	typedef enum logic [1:0] {
		LGATE_ST_OFF = 2'b00,
		LGATE_ST_WAIT_RESTART = 2'b01,
		LGATE_ST_ARMING = 2'b10,
		LGATE_ST_READY = 2'b11
	} lgate_state_t;
endpackage

// ==== lgate_sync.sv ====
// Purpose: Three-stage synchroniser with agreement filter
// Assumes: Asynchronous input level
// Notes: Output changes once stages two and three agree
`timescale 1ns/1ps
module lgate_sync (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Level in and out
	input wire logic in_async,
	output logic out_sync
);
	logic s1_q, s1_d, s2_q, s2_d, s3_q, s3_d, o_q, o_d;

	always_comb begin
		s1_d = in_async;
		s2_d = s1_q;
		s3_d = s2_q;
		o_d = (s2_q == s3_q) ? s3_q : o_q;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
			o_q <= 1'b0;
		end else begin
			s1_q <= s1_d;
			s2_q <= s2_d;
			s3_q <= s3_d;
			o_q <= o_d;
		end
	end

	assign out_sync = o_q;
endmodule

// ==== lgate_checker.sv ====
// Purpose: Port checks for laser enable gating
// Assumes: Settled inputs; keyed checks gated by HAS_KEY
// Notes: Eight cycles covers input sync latency
`timescale 1ns/1ps
module lgate_checker #(
	parameter int unsigned ARM_CYCLES = 20,
	parameter bit HAS_KEY = 1'b1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Inputs
	input wire logic interlock_in,
	input wire logic gate_request_in,
	input wire logic restart_in,
	input wire logic pwm_in,
	input wire logic key_on_in,
	input wire logic shutter_open_in,
	// Outputs
	input wire logic ready_out,
	input wire logic beam_gate_indicator,
	input wire logic rf_enable,
	input wire logic rf_drive
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	logic [31:0] rdy_n;
	always_ff @(posedge clk) rdy_n <= (rst || !ready_out) ? 32'h0 : rdy_n + 32'h1;
	////////////////////////////////////////////////////////////////
	property p_il; !interlock_in [*8] |-> !rf_enable; endproperty
	a_il: assert property (p_il) else $error("rf on, interlock open");
	property p_gr; !gate_request_in [*8] |-> !rf_enable && !beam_gate_indicator; endproperty
	a_gr: assert property (p_gr) else $error("rf on, no request");
	property p_sh; (HAS_KEY && !shutter_open_in) [*8] |-> !rf_enable; endproperty
	a_sh: assert property (p_sh) else $error("rf on, shutter shut");
	property p_rs; restart_in [*8] |-> !ready_out && !rf_enable; endproperty
	a_rs: assert property (p_rs) else $error("on during restart");
	property p_rd; rf_enable |-> ready_out && beam_gate_indicator; endproperty
	a_rd: assert property (p_rd) else $error("rf on, status off");
	property p_dr; rf_drive |-> rf_enable || $past(rf_enable); endproperty
	a_dr: assert property (p_dr) else $error("drive, not enabled");
	property p_pw; !pwm_in [*8] |-> !rf_drive; endproperty
	a_pw: assert property (p_pw) else $error("drive, no pwm");
	property p_ar; HAS_KEY && $rose(rf_enable) |-> rdy_n >= ARM_CYCLES - 1; endproperty
	a_ar: assert property (p_ar) else $error("arming too short");
endmodule
bind lgate_top lgate_checker #(.ARM_CYCLES(ARM_CYCLES), .HAS_KEY(HAS_KEY)) i_chk (.*);

// ==== lgate_ctl_model.sv ====
// Purpose: Controller power command source
// Assumes: High time below period
// Notes: Period 1600 cycles
`timescale 1ns/1ps
module lgate_ctl_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Command
	input wire logic [10:0] hi,
	output logic pwm
);
	logic [10:0] n;
	always_ff @(posedge clk) begin
		n <= (rst || n == 11'h63f) ? 11'h0 : n + 11'h1;
		pwm <= !rst && n < hi;
	end
endmodule

// ==== tb.sv ====
// Purpose: Bench for laser enable gating
// Assumes: Keyed and keyless copies, arming 20 cycles
// Notes: Table rows are il,req,rs,key,sh then ready,en
`timescale 1ns/1ps
module tb;
	logic clk, rst, il, req, rs, key, sh, pwm, rdy, ind, en, drv;
	logic rdy_nk, ind_nk, en_nk, drv_nk;
	logic [1:0] exp_nk;
	logic [10:0] hi;
	int bad_count, checks_done;
	logic [6:0] s [16] = '{7'h6f, 7'h4e, 7'h6e, 7'h6f, 7'h6a, 7'h6f, 7'h2c, 7'h6c,
		7'h7c, 7'h6e, 7'h6f, 7'h64, 7'h6f, 7'h7c, 7'h6e, 7'h6f};
	int w [16] = '{40, 12, 12, 40, 12, 40, 12, 40, 12, 12, 40, 12, 40, 12, 12, 40};
	lgate_top #(.ARM_CYCLES(20)) i_dut (.clk(clk), .rst(rst), .interlock_in(il),
		.gate_request_in(req), .restart_in(rs), .pwm_in(pwm), .key_on_in(key),
		.shutter_open_in(sh), .ready_out(rdy), .beam_gate_indicator(ind),
		.rf_enable(en), .rf_drive(drv));
	lgate_top #(.ARM_CYCLES(20), .HAS_KEY(1'b0)) i_dut_nk (.clk(clk), .rst(rst),
		.interlock_in(il), .gate_request_in(req), .restart_in(rs), .pwm_in(pwm),
		.key_on_in(key), .shutter_open_in(sh), .ready_out(rdy_nk),
		.beam_gate_indicator(ind_nk), .rf_enable(en_nk), .rf_drive(drv_nk));
	lgate_ctl_model i_ctl (.clk(clk), .rst(rst), .hi(hi), .pwm(pwm));
	task automatic check(input logic [1:0] seen, input logic [1:0] exp);
		checks_done++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic final_report;
		$display("mismatches=%0d checks=%0d", bad_count, checks_done);
		if (bad_count == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial begin
		#40000;
		bad_count++;
		final_report();
	end
	initial begin
		{rst, il, req, rs, key, sh} = 6'h20;
		hi = 11'h0;
		repeat (10) @(posedge clk);
		void'($urandom(86978));
		hi <= 11'(50 + $urandom % 1500);
		for (int i = 0; i < 16; i++) begin
			@(posedge clk);
			rst <= 1'b0;
			// restart toggled only well after reset
			{il, req, rs, key, sh} <= s[i][6:2];
			repeat (w[i] - 1) @(posedge clk);
			#1;
			check({rdy, en}, s[i][1:0]);
			if (s[i][1]) check({1'b0, ind}, {1'b0, s[i][5] & s[i][2]});
			// Keyless: no latch, no delay, shutter ignored
			exp_nk = {s[i][6] & ~s[i][4], s[i][6] & ~s[i][4] & s[i][5]};
			check({rdy_nk, en_nk}, exp_nk);
			check({1'b0, ind_nk}, {1'b0, s[i][5]});
		end
		@(posedge pwm);
		repeat (20) @(posedge clk);
		#1 check({1'b0, drv}, 2'h1);
		check({1'b0, drv_nk}, 2'h1);
		@(negedge pwm);
		repeat (20) @(posedge clk);
		#1 check({1'b0, drv}, 2'h0);
		check({1'b0, drv_nk}, 2'h0);
		final_report();
	end
endmodule
